// ---- rtl/power_mode_transition_ctrl.sv ----
// power-mode control with interrupt enables, behind an axi4-lite slave
//
// The address map and register access over AXI4-Lite were left to the implementer.
`include "power_mode_regs.svh"
module power_mode_transition_ctrl #(
    parameter int ADDR_W = 8,
    parameter int FREQ_W = 3
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic sleep_exec, // cpu executed sleep, one-cycle pulse
    input wire logic cpu_irq_mask, // cpu interrupt mask bit
    input wire logic [5:0] wakeup_pins_n, // wakeup pins, active low
    input wire logic ext_irq_pin_three_n, // external pin three, active low
    input wire logic ext_irq_pin_zero_n, // external pin zero, active low
    output power_mode_pkg::irq_req_t irq_req, // requests to the cpu
    output power_mode_pkg::power_mode_t power_mode, // current mode
    output logic cpu_clk_run, // cpu clock runs when high
    output logic [FREQ_W-1:0] active_freq, // applied frequency select
    output logic [15:0] periph_clk_run, // per-peripheral clock runs
    output logic irq // level interrupt to software
);
    import power_mode_pkg::*;

    logic [7:0] ien_q;
    logic [FREQ_W:0] sc2_q;
    logic [7:0] stby1_q;
    logic [7:0] stby2_q;
    logic [3:0] flag_q;
    logic [3:0] mask_q;
    logic [3:0] hold_q;
    logic [3:0] req_en;
    logic [3:0] req_vec;
    logic [3:0] evt;
    logic [7:0] fall;
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic wr_hit;
    logic wr_en;
    logic [7:0] wbyte;
    logic [31:0] rd_word;
    logic rd_hit;
    logic sleep_go;
    logic direct_ok;

    // register decode, shared by the read and write paths
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        case (a)
            `OFS_IRQ_ENABLE, `OFS_SYS_CTRL_TWO, `OFS_STANDBY_ONE,
            `OFS_STANDBY_TWO, `OFS_IRQ_STATUS, `OFS_IRQ_MASK,
            `OFS_MODE_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // pin synchronisers and falling-edge detection
    pin_fall_detect #(
        .WIDTH(8)
    ) u_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins_n({ext_irq_pin_zero_n, ext_irq_pin_three_n, wakeup_pins_n}),
        .fall(fall)
    );

    // axi4-lite write channel
    // address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full_q <= 1'b0;
        end
    end

    assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_hit = mapped(aw_addr_q);
    // registers are at most one byte wide, so only lane zero writes them
    assign wr_en = wr_go && wr_hit && w_strb_q[0];
    assign wbyte = w_data_q[7:0];

    // readies stay low while a word waits, which back-pressures the master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_q && !s_axi_awready &&
                !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full_q && !s_axi_wready &&
                !(s_axi_wvalid && s_axi_wready);
        end
    end

    // response once both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // axi4-lite read channel
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `OFS_IRQ_ENABLE: rd_word[7:0] = ien_q | `IEN_FIXED_ONES;
            `OFS_SYS_CTRL_TWO: rd_word[FREQ_W:0] = sc2_q;
            `OFS_STANDBY_ONE: rd_word[7:0] = stby1_q;
            `OFS_STANDBY_TWO: rd_word[7:0] = stby2_q;
            `OFS_IRQ_STATUS: rd_word[3:0] = flag_q;
            `OFS_IRQ_MASK: rd_word[3:0] = mask_q;
            `OFS_MODE_STATUS: rd_word[FREQ_W+1:0] = {active_freq, power_mode};
            default: rd_word = 32'h0000_0000;
        endcase
    end
    assign rd_hit = mapped(s_axi_araddr);

    // one read at a time; arready pulses for the accepting edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid &&
                !s_axi_arready;
        end
    end

    // control registers
    // only the four enable bits are storage; the rest read fixed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_q <= `IEN_RESET;
        end else if (wr_en && aw_addr_q == `OFS_IRQ_ENABLE) begin
            ien_q <= wbyte & `IEN_WRITABLE;
        end
    end

    // frequency select is stored here but applied only on sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sc2_q <= `SC2_RESET;
        end else if (wr_en && aw_addr_q == `OFS_SYS_CTRL_TWO) begin
            sc2_q <= wbyte[FREQ_W:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stby1_q <= `STANDBY_RESET;
            stby2_q <= `STANDBY_RESET;
        end else if (wr_en && aw_addr_q == `OFS_STANDBY_ONE) begin
            stby1_q <= wbyte;
        end else if (wr_en && aw_addr_q == `OFS_STANDBY_TWO) begin
            stby2_q <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `MASK_RESET;
        end else if (wr_en && aw_addr_q == `OFS_IRQ_MASK) begin
            mask_q <= wbyte[3:0];
        end
    end

    // interrupt sources
    assign evt[`FLAG_EXT_IRQ_PIN_ZERO] = fall[7];
    assign evt[`FLAG_EXT_IRQ_PIN_THREE] = fall[6];
    assign evt[`FLAG_WAKEUP] = |fall[5:0];
    assign evt[`FLAG_DT] = power_mode == MODE_DIRECT;

    // sticky flags: a new event wins over a one written to clear it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= `FLAG_RESET;
        end else if (wr_en && aw_addr_q == `OFS_IRQ_STATUS) begin
            flag_q <= (flag_q & ~wbyte[3:0]) | evt;
        end else begin
            flag_q <= flag_q | evt;
        end
    end

    assign req_en[`FLAG_DT] = ien_q[`IEN_DT_BIT];
    assign req_en[`FLAG_WAKEUP] = ien_q[`IEN_WP_BIT];
    assign req_en[`FLAG_EXT_IRQ_PIN_THREE] = ien_q[`IEN_EXT_IRQ_PIN_THREE_BIT];
    assign req_en[`FLAG_EXT_IRQ_PIN_ZERO] = ien_q[`IEN_EXT_IRQ_PIN_ZERO_BIT];

    // an enable cleared while unmasked and a request pending keeps the
    // request alive until its flag goes; software is expected to mask
    // first, this only guards the unmasked case
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= '0;
        end else if (wr_en && aw_addr_q == `OFS_IRQ_ENABLE &&
                     !cpu_irq_mask) begin
            hold_q <= (hold_q | (req_en & (flag_q | evt))) & flag_q;
        end else begin
            hold_q <= hold_q & flag_q;
        end
    end

    assign req_vec = flag_q & (req_en | hold_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req <= '0;
        end else begin
            irq_req.direct_transition <= req_vec[`FLAG_DT];
            irq_req.wakeup <= req_vec[`FLAG_WAKEUP];
            irq_req.ext_pin_three <= req_vec[`FLAG_EXT_IRQ_PIN_THREE];
            irq_req.ext_pin_zero <= req_vec[`FLAG_EXT_IRQ_PIN_ZERO];
        end
    end

    // software interrupt: any flag whose mask bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_q & mask_q);
        end
    end

    // mode sequencing
    assign sleep_go = sleep_exec && power_mode == MODE_ACTIVE;
    // direct transition only with its enable set and the cpu unmasked
    assign direct_ok = sc2_q[`SC2_DIRECT_TRANSITION_ON_BIT] && ien_q[`IEN_DT_BIT] &&
        !cpu_irq_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_mode <= MODE_ACTIVE;
        end else begin
            unique case (power_mode)
                MODE_ACTIVE: begin
                    if (sleep_go && direct_ok) begin
                        power_mode <= MODE_DIRECT;
                    end else if (sleep_go && sc2_q[`SC2_DIRECT_TRANSITION_ON_BIT] &&
                                 cpu_irq_mask) begin
                        power_mode <= MODE_SLEEP_LOCKED;
                    end else if (sleep_go) begin
                        power_mode <= MODE_SLEEP;
                    end
                end
                // one cycle to switch rate, then back to active
                MODE_DIRECT: power_mode <= MODE_ACTIVE;
                MODE_SLEEP: begin
                    if (|req_vec) begin
                        power_mode <= MODE_ACTIVE;
                    end
                end
                // only reset leaves this state
                MODE_SLEEP_LOCKED: power_mode <= MODE_SLEEP_LOCKED;
            endcase
        end
    end

    // selected rate reaches the clock tree only at a sleep instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_freq <= '0;
        end else if (sleep_go) begin
            active_freq <= sc2_q[`SC2_FREQ_LSB +: FREQ_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_run <= 1'b1;
        end else begin
            cpu_clk_run <= !(power_mode == MODE_SLEEP ||
                power_mode == MODE_SLEEP_LOCKED) || (|req_vec &&
                power_mode == MODE_SLEEP);
        end
    end

    // per-peripheral clock gating, one cycle behind the register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_clk_run <= '1;
        end else begin
            periph_clk_run <= ~{stby2_q, stby1_q};
        end
    end
endmodule

// ---- pkg/power_mode_regs.svh ----
// register offsets, field positions and reset values of the power-mode block
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH
`define OFS_IRQ_ENABLE 8'h00
`define OFS_SYS_CTRL_TWO 8'h04
`define OFS_STANDBY_ONE 8'h08
`define OFS_STANDBY_TWO 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_MODE_STATUS 8'h18
`define IEN_DT_BIT 7
`define IEN_WP_BIT 5
`define IEN_RSV_ONE_BIT 4
`define IEN_EXT_IRQ_PIN_THREE_BIT 3
`define IEN_EXT_IRQ_PIN_ZERO_BIT 0
`define IEN_WRITABLE 8'ha9
`define IEN_FIXED_ONES 8'h10
`define IEN_RESET 8'h00
`define SC2_FREQ_LSB 0
`define SC2_DIRECT_TRANSITION_ON_BIT 3
`define SC2_RESET 4'h0
`define STANDBY_RESET 8'h00
`define FLAG_EXT_IRQ_PIN_ZERO 0
`define FLAG_EXT_IRQ_PIN_THREE 1
`define FLAG_WAKEUP 2
`define FLAG_DT 3
`define FLAG_RESET 4'h0
`define MASK_RESET 4'h0
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10
`endif

// ---- pkg/power_mode_pkg.sv ----
// types shared by the power-mode block
package power_mode_pkg;
    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_DIRECT,
        MODE_SLEEP,
        MODE_SLEEP_LOCKED
    } power_mode_t;

    // interrupt requests handed to the cpu
    typedef struct packed {
        logic direct_transition;
        logic wakeup;
        logic ext_pin_three;
        logic ext_pin_zero;
    } irq_req_t;
endpackage

// ---- rtl/pin_fall_detect.sv ----
// synchronises active-low pins and pulses on each falling edge
module pin_fall_detect #(
    parameter int WIDTH = 8
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [WIDTH-1:0] pins_n, // asynchronous active-low pins
    output logic [WIDTH-1:0] fall // one-cycle pulse per falling edge
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] last_q;

    // two-stage synchroniser; idle pins rest high, so reset to ones
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '1;
            sync_q <= '1;
            last_q <= '1;
        end else begin
            meta_q <= pins_n;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // edge pulse is registered so it never glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fall <= '0;
        end else begin
            fall <= last_q & ~sync_q;
        end
    end
endmodule

// ---- verification/power_mode_transition_ctrl_sva.sv ----
// concurrent checks on the ports of the power-mode block
module power_mode_transition_ctrl_sva #(
    parameter int FREQ_W = 3
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic [1:0] s_axi_bresp, // b response
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic sleep_exec, // sleep pulse
    input wire logic cpu_irq_mask, // cpu mask bit
    input wire power_mode_pkg::irq_req_t irq_req, // requests
    input wire power_mode_pkg::power_mode_t power_mode, // mode
    input wire logic cpu_clk_run, // cpu clock gate
    input wire logic [FREQ_W-1:0] active_freq, // applied freq
    input wire logic [15:0] periph_clk_run // peripheral gates
);
    timeunit 1ns;
    timeprecision 100ps;
    import power_mode_pkg::*;
    logic asleep;
    // both sleep flavours stop the cpu clock
    assign asleep = power_mode inside {MODE_SLEEP, MODE_SLEEP_LOCKED};
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    direct_one_cycle_a: assert property (
        power_mode == MODE_DIRECT |=> power_mode == MODE_ACTIVE)
        else $error("direct mode did not return to active");
    direct_cause_a: assert property (
        power_mode == MODE_DIRECT && $past(power_mode) == MODE_ACTIVE
        |-> $past(sleep_exec) && !$past(cpu_irq_mask))
        else $error("direct mode without unmasked sleep");
    direct_irq_a: assert property (
        $rose(power_mode == MODE_DIRECT) |-> ##[1:3] irq_req.direct_transition)
        else $error("no direct-transition request after transition");
    locked_hold_a: assert property (
        power_mode == MODE_SLEEP_LOCKED |=> power_mode == MODE_SLEEP_LOCKED)
        else $error("locked sleep was left without reset");
    locked_cause_a: assert property (
        power_mode == MODE_SLEEP_LOCKED && $past(power_mode) == MODE_ACTIVE
        |-> $past(sleep_exec) && $past(cpu_irq_mask))
        else $error("locked sleep without masked sleep");
    sleep_cause_a: assert property (
        power_mode == MODE_SLEEP && $past(power_mode) == MODE_ACTIVE
        |-> $past(sleep_exec))
        else $error("sleep entered without sleep pulse");
    freq_hold_a: assert property (
        !sleep_exec |=> $stable(active_freq))
        else $error("frequency changed without sleep");
    sleep_clk_off_a: assert property (
        asleep ##1 asleep |-> !cpu_clk_run)
        else $error("cpu clock runs in sleep");
    gate_change_a: assert property (
        $changed(periph_clk_run) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("peripheral gate changed without a write");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule

bind power_mode_transition_ctrl power_mode_transition_ctrl_sva #(
    .FREQ_W(FREQ_W)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .sleep_exec(sleep_exec), .cpu_irq_mask(cpu_irq_mask),
    .irq_req(irq_req), .power_mode(power_mode), .cpu_clk_run(cpu_clk_run),
    .active_freq(active_freq), .periph_clk_run(periph_clk_run));

// ---- verification/power_mode_transition_ctrl_tb.sv ----
// self-checking bench of the power-mode block over axi4-lite
`include "power_mode_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module power_mode_transition_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import power_mode_pkg::*;
    typedef struct {logic [33:0] v; string nm;} note_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_exec, irq;
    logic cpu_irq_mask, ext_irq_pin_three_n, ext_irq_pin_zero_n, cpu_clk_run;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] wakeup_pins_n;
    logic [2:0] active_freq, f;
    logic [15:0] periph_clk_run;
    irq_req_t irq_req;
    power_mode_t power_mode;
    int fails, n_tests, idx, k;
    note_t nt;
    note_t exp_q[$];
    power_mode_transition_ctrl dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sleep_exec(sleep_exec),
        .cpu_irq_mask(cpu_irq_mask), .wakeup_pins_n(wakeup_pins_n),
        .ext_irq_pin_three_n(ext_irq_pin_three_n),
        .ext_irq_pin_zero_n(ext_irq_pin_zero_n), .irq_req(irq_req),
        .power_mode(power_mode), .cpu_clk_run(cpu_clk_run),
        .active_freq(active_freq), .periph_clk_run(periph_clk_run),
        .irq(irq));
    // 40 mhz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // write cycle; aw and w offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dv,
            input logic [3:0] st, input logic [1:0] rsp);
        exp_q.push_back('{{rsp, 32'h0}, "write response"});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 50);
        s_axi_bready <= 1'b0;
        if (k >= 50) fails++;
    endtask
    // read cycle; the watcher compares when the data arrives
    task automatic rd(input logic [7:0] a, input logic [31:0] dv,
            input logic [1:0] rsp, input string nm);
        exp_q.push_back('{{rsp, dv}, nm});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 50);
        s_axi_rready <= 1'b0;
        if (k >= 50) fails++;
    endtask
    // watcher: oldest note against each bus answer
    always @(posedge aclk) begin
        if (aresetn && ((s_axi_rvalid && s_axi_rready) ||
                (s_axi_bvalid && s_axi_bready))) begin
            if (exp_q.size() == 0) fails++;
            else begin
                nt = exp_q.pop_front();
                if (s_axi_rvalid) `CHK(nt.nm, nt.v, {s_axi_rresp, s_axi_rdata})
                else `CHK(nt.nm, nt.v, {s_axi_bresp, 32'h0})
            end
        end
    end
    // watchdog sized well above the whole sequence
    initial begin
        #500000;
        fails++;
        report_and_stop();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, sleep_exec, cpu_irq_mask} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {wakeup_pins_n, ext_irq_pin_three_n, ext_irq_pin_zero_n} = 8'hff;
        fails = 0;
        n_tests = 0;
        d = $urandom(69979);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_IRQ_ENABLE, 32'h10, `AXI_RESP_OKAY, "enable reset");
        for (int i = 1; i < 7; i++) rd(8'(i * 4), 0, 2'b00, "reset value");
        `CHK("peripheral gates", 16'hffff, periph_clk_run)
        rd(8'h1c, 0, `AXI_RESP_SLVERR, "unmapped read");
        wr(8'h1c, $urandom, 4'hf, `AXI_RESP_SLVERR);
        $display("test reset values done");
        // random words: only bits 7, 5, 3, 0 take, bit 4 stays one
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            e = {24'h0, (d[7:0] & `IEN_WRITABLE) | `IEN_FIXED_ONES};
            wr(`OFS_IRQ_ENABLE, d, 4'h1, `AXI_RESP_OKAY);
            rd(`OFS_IRQ_ENABLE, e, `AXI_RESP_OKAY, "enable bits");
        end
        wr(`OFS_IRQ_ENABLE, ~e, 4'he, `AXI_RESP_OKAY);
        rd(`OFS_IRQ_ENABLE, e, `AXI_RESP_OKAY, "strobe off");
        d = $urandom;
        wr(`OFS_STANDBY_ONE, d, 4'h1, `AXI_RESP_OKAY);
        wr(`OFS_STANDBY_TWO, d >> 8, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("peripheral gates", ~d[15:0], periph_clk_run)
        wr(`OFS_STANDBY_ONE, 0, 4'h1, `AXI_RESP_OKAY);
        wr(`OFS_STANDBY_TWO, 0, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("peripheral gates", 16'hffff, periph_clk_run)
        $display("test registers done");
        wr(`OFS_IRQ_ENABLE, 32'h01, 4'h1, `AXI_RESP_OKAY);
        @(posedge aclk) ext_irq_pin_zero_n <= 1'b0;
        @(posedge aclk) ext_irq_pin_three_n <= 1'b0;
        tick(8);
        `CHK("pin requests", 4'b0001, irq_req)
        wr(`OFS_IRQ_ENABLE, 32'h09, 4'h1, `AXI_RESP_OKAY);
        rd(`OFS_IRQ_STATUS, 32'h3, `AXI_RESP_OKAY, "flags");
        `CHK("pin requests", 4'b0011, irq_req)
        wr(`OFS_IRQ_MASK, 32'h2, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("interrupt", 1'b1, irq)
        // enable cleared unmasked while pin zero is pending
        wr(`OFS_IRQ_ENABLE, 32'h08, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("held request", 4'b0011, irq_req)
        {ext_irq_pin_three_n, ext_irq_pin_zero_n} <= 2'b11;
        wr(`OFS_IRQ_MASK, 32'h0, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("masked interrupt", 1'b0, irq)
        wr(`OFS_IRQ_STATUS, 32'hf, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("cleared requests", 4'b0000, irq_req)
        idx = $urandom % 6;
        @(posedge aclk) wakeup_pins_n[idx] <= 1'b0;
        tick(8);
        `CHK("wakeup disabled", 4'b0000, irq_req)
        wr(`OFS_IRQ_ENABLE, 32'h20, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("wakeup enabled", 4'b0100, irq_req)
        wakeup_pins_n <= 6'h3f;
        wr(`OFS_IRQ_STATUS, 32'hf, 4'h1, `AXI_RESP_OKAY);
        $display("test pin interrupts done");
        f = 3'($urandom % 7) + 3'h1;
        wr(`OFS_IRQ_ENABLE, 32'h80, 4'h1, `AXI_RESP_OKAY);
        wr(`OFS_SYS_CTRL_TWO, {28'h0, 1'b1, f}, 4'h1, `AXI_RESP_OKAY);
        `CHK("freq before sleep", 3'h0, active_freq)
        @(posedge aclk) sleep_exec <= 1'b1;
        @(posedge aclk) sleep_exec <= 1'b0;
        #1;
        `CHK("mode", MODE_DIRECT, power_mode)
        `CHK("freq", f, active_freq)
        tick(1);
        `CHK("mode", MODE_ACTIVE, power_mode)
        tick(2);
        `CHK("direct request", 1'b1, irq_req.direct_transition)
        rd(`OFS_MODE_STATUS, {27'h0, f, 2'b00}, 2'b00, "mode status");
        wr(`OFS_IRQ_STATUS, 32'hf, 4'h1, `AXI_RESP_OKAY);
        // direct enable off: plain sleep, pin zero wakes it
        wr(`OFS_IRQ_ENABLE, 32'h01, 4'h1, `AXI_RESP_OKAY);
        @(posedge aclk) sleep_exec <= 1'b1;
        @(posedge aclk) sleep_exec <= 1'b0;
        tick(1);
        `CHK("mode", MODE_SLEEP, power_mode)
        `CHK("cpu clock", 1'b0, cpu_clk_run)
        @(posedge aclk) ext_irq_pin_zero_n <= 1'b0;
        for (k = 0; k < 12 && power_mode != MODE_ACTIVE; k++) tick(1);
        `CHK("woken mode", MODE_ACTIVE, power_mode)
        ext_irq_pin_zero_n <= 1'b1;
        wr(`OFS_IRQ_STATUS, 32'hf, 4'h1, `AXI_RESP_OKAY);
        $display("test direct and sleep done");
        wr(`OFS_IRQ_ENABLE, 32'h81, 4'h1, `AXI_RESP_OKAY);
        @(posedge aclk) {cpu_irq_mask, sleep_exec} <= 2'b11;
        @(posedge aclk) sleep_exec <= 1'b0;
        #1;
        `CHK("mode", MODE_SLEEP_LOCKED, power_mode)
        @(posedge aclk) ext_irq_pin_zero_n <= 1'b0;
        tick(10);
        `CHK("locked mode", MODE_SLEEP_LOCKED, power_mode)
        `CHK("locked request", 4'b0001, irq_req)
        wr(`OFS_IRQ_ENABLE, 32'h80, 4'h1, `AXI_RESP_OKAY);
        tick(2);
        `CHK("masked clear", 4'b0000, irq_req)
        @(posedge aclk) {aresetn, cpu_irq_mask, ext_irq_pin_zero_n} <= 3'b001;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        `CHK("mode after reset", MODE_ACTIVE, power_mode)
        `CHK("cpu clock", 1'b1, cpu_clk_run)
        $display("test locked sleep done");
        report_and_stop();
    end
endmodule
